// *** verilog/dce_pkg.sv ***
// Purpose: shared constants and types for the context entry decoder
// Assumes: 32-bit classic Wishbone register access, byte addresses
// Notes:   entry bits 95:72 are stored by software but not decoded here
package dce_pkg;

  // register byte offsets
  localparam logic [7:0] DCE_OFS_ENTRY_LO  = 8'h00; // entry bits 31:0
  localparam logic [7:0] DCE_OFS_ENTRY_MID = 8'h04; // entry bits 63:32
  localparam logic [7:0] DCE_OFS_ENTRY_HI  = 8'h08; // entry bits 95:64
  localparam logic [7:0] DCE_OFS_CAPS      = 8'h0C; // capability setup
  localparam logic [7:0] DCE_OFS_STATUS    = 8'h10; // read-only status
  localparam int         DCE_NUM_RW        = 4;

  // context entry field positions (in the 96-bit stored image)
  localparam int DCE_B_PRESENT   = 0;
  localparam int DCE_B_FLT_SUPP  = 1;
  localparam int DCE_B_TT_LO     = 2;
  localparam int DCE_B_RSV_LO    = 4;
  localparam int DCE_B_RSV_HI    = 11;
  localparam int DCE_B_ROOT_LO   = 12;
  localparam int DCE_B_ROOT_HI   = 63;
  localparam int DCE_B_AW_LO     = 64;
  localparam int DCE_B_SPARE_LO  = 67; // software_spare_bits, never read
  localparam int DCE_B_RSV_TOP   = 71;
  localparam int DCE_PAGE_SHIFT  = 12;

  // capability register field positions
  localparam int DCE_C_HPW_LO    = 0;  // host_phys_width, 7 bits
  localparam int DCE_C_BMAP_LO   = 8;  // supported_width_bitmap, 5 bits
  localparam int DCE_C_DEVCACHE  = 13; // device_side_cache_support
  localparam int DCE_C_PASSTHRU  = 14; // passthrough_support
  localparam int DCE_C_MGW_LO    = 16; // max_guest_width, 7 bits
  localparam logic [31:0] DCE_CAPS_RST = 32'h0030_7430;

  // walk width codes
  localparam logic [2:0] DCE_AW_30 = 3'h0;
  localparam logic [2:0] DCE_AW_39 = 3'h1;
  localparam logic [2:0] DCE_AW_48 = 3'h2;
  localparam logic [2:0] DCE_AW_64 = 3'h4;
  localparam logic [6:0] DCE_W_30  = 7'h1E;
  localparam logic [6:0] DCE_W_39  = 7'h27;
  localparam logic [6:0] DCE_W_48  = 7'h30;
  localparam logic [6:0] DCE_W_64  = 7'h40;
  localparam logic [2:0] DCE_LV_2  = 3'h2;
  localparam logic [2:0] DCE_LV_3  = 3'h3;
  localparam logic [2:0] DCE_LV_4  = 3'h4;
  localparam logic [2:0] DCE_LV_6  = 3'h6;

  // translation type codes
  typedef enum logic [1:0] {
    DCE_TT_UNTR_ONLY = 2'h0,
    DCE_TT_ALL       = 2'h1,
    DCE_TT_PASS      = 2'h2,
    DCE_TT_RSVD      = 2'h3
  } dce_tt_type;

  // kinds of incoming request
  typedef enum logic [1:0] {
    DCE_RQ_UNTRANSLATED = 2'h0,
    DCE_RQ_TRANSLATED   = 2'h1,
    DCE_RQ_XLATE_REQ    = 2'h2
  } dce_kind_type;

  // verdict on a request
  typedef enum logic [1:0] {
    DCE_ACT_BLOCK = 2'h0,
    DCE_ACT_PASS  = 2'h1,
    DCE_ACT_WALK  = 2'h3
  } dce_act_type;

  typedef struct packed {
    dce_kind_type kind;
    logic [63:0]  addr;
  } dce_req_type;

  typedef struct packed {
    dce_act_type  act;
    logic [2:0]   levels;      // walk depth when act is walk
    logic [51:0]  root_page;   // table_root_pointer, 4KB frame number
    logic         fault;       // remapping fault detected
    logic         fault_report;// fault to be recorded and reported
    logic         cfg_fault;   // entry programming fault
    logic         platform_err;// above max_guest_width, not a fault
  } dce_rsp_type;

endpackage

// *** verilog/dce_decode.sv ***
// Purpose: decode a context entry and judge each DMA request against it
// Assumes: request inputs synchronous to clk_sys_i; one verdict per request
// Notes:   verdict appears on the cycle after the request is presented
//
// Local design decisions: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module dce_decode (
  input  wire logic                 clk_sys_i,
  input  wire logic                 rst_b_i,
  // classic wishbone slave
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [7:0]           wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  // request in, verdict out
  input  wire logic                 req_valid_i,
  input  wire dce_pkg::dce_req_type req_i,
  output logic                      rsp_valid_o,
  output dce_pkg::dce_rsp_type      rsp_o
);

  logic [31:0]          regs_r [dce_pkg::DCE_NUM_RW];
  logic                 ack_r;
  logic [31:0]          rdat_r;
  logic                 rsp_valid_r;
  dce_pkg::dce_rsp_type rsp_r;
  dce_pkg::dce_rsp_type rsp_nxt;

  // bus decode
  wire        bus_go   = wb_cyc_i & wb_stb_i & ~ack_r;
  wire        wr_go    = wb_cyc_i & wb_stb_i & wb_we_i & ack_r; // at ack
  wire [2:0]  reg_idx  = wb_adr_i[4:2];
  wire        hit_rw   = (wb_adr_i < dce_pkg::DCE_OFS_STATUS) &
                         (wb_adr_i[1:0] == 2'h0);
  wire        hit_stat = (wb_adr_i == dce_pkg::DCE_OFS_STATUS);

  // stored entry image and capability fields
  wire [95:0] entry   = {regs_r[2], regs_r[1], regs_r[0]};
  wire [31:0] caps    = regs_r[3];
  wire [6:0]  hpw     = caps[dce_pkg::DCE_C_HPW_LO +: 7];
  wire [4:0]  bmap    = caps[dce_pkg::DCE_C_BMAP_LO +: 5];
  wire        dc_sup  = caps[dce_pkg::DCE_C_DEVCACHE];
  wire        pt_sup  = caps[dce_pkg::DCE_C_PASSTHRU];
  wire [6:0]  mgw     = caps[dce_pkg::DCE_C_MGW_LO +: 7];

  // entry fields; bits 70:67 are left unread
  wire        present  = entry[dce_pkg::DCE_B_PRESENT];
  wire        flt_supp = entry[dce_pkg::DCE_B_FLT_SUPP];
  wire [1:0]  tt_raw   = entry[dce_pkg::DCE_B_TT_LO +: 2];
  wire [2:0]  aw_code  = entry[dce_pkg::DCE_B_AW_LO +: 3];
  wire [51:0] root_pg  = entry[dce_pkg::DCE_B_ROOT_HI:dce_pkg::DCE_B_ROOT_LO];
  wire [63:0] root_adr = 64'(root_pg) << dce_pkg::DCE_PAGE_SHIFT;
  wire        rsv_set  = (|entry[dce_pkg::DCE_B_RSV_HI:dce_pkg::DCE_B_RSV_LO])
                       | entry[dce_pkg::DCE_B_RSV_TOP];

  // width code to width and depth
  logic [6:0] aw_width;
  logic [2:0] aw_levels;
  logic       aw_known;
  always_comb begin
    aw_width  = dce_pkg::DCE_W_64;
    aw_levels = dce_pkg::DCE_LV_6;
    aw_known  = 1'b1;
    unique case (aw_code)
      dce_pkg::DCE_AW_30: begin
        aw_width  = dce_pkg::DCE_W_30;
        aw_levels = dce_pkg::DCE_LV_2;
      end
      dce_pkg::DCE_AW_39: begin
        aw_width  = dce_pkg::DCE_W_39;
        aw_levels = dce_pkg::DCE_LV_3;
      end
      dce_pkg::DCE_AW_48: begin
        aw_width  = dce_pkg::DCE_W_48;
        aw_levels = dce_pkg::DCE_LV_4;
      end
      dce_pkg::DCE_AW_64: begin
        aw_width  = dce_pkg::DCE_W_64;
        aw_levels = dce_pkg::DCE_LV_6;
      end
      default: aw_known = 1'b0;
    endcase
  end

  // width code must be defined and listed as supported; codes above the
  // bitmap read as unsupported instead of indexing past it
  wire [7:0] bmap_ext = {3'h0, bmap};
  wire       aw_ok    = aw_known & bmap_ext[aw_code];

  // translation type with capability-dependent reserved encodings
  wire tt_multi = (tt_raw == dce_pkg::DCE_TT_UNTR_ONLY) |
                  (tt_raw == dce_pkg::DCE_TT_ALL);
  wire tt_bad   = (tt_raw == dce_pkg::DCE_TT_RSVD)
                | ((tt_raw == dce_pkg::DCE_TT_ALL) & ~dc_sup)
                | ((tt_raw == dce_pkg::DCE_TT_PASS) & ~pt_sup);

  // root pointer high bits above host width are reserved for walks
  wire root_bad = tt_multi & (|(root_adr >> hpw));

  // programming fault only counts for a present entry
  wire cfg_bad  = present & (rsv_set | tt_bad | ~aw_ok | root_bad);

  // request address range checks
  wire over_aw  = (aw_width != dce_pkg::DCE_W_64) &
                  (|(req_i.addr >> aw_width));
  wire over_mgw = (mgw < dce_pkg::DCE_W_64) &
                  (|(req_i.addr >> mgw)) &
                  (req_i.kind != dce_pkg::DCE_RQ_TRANSLATED);

  // kind accepted by the selected type
  logic kind_ok;
  always_comb begin
    kind_ok = 1'b0;
    unique case (tt_raw)
      dce_pkg::DCE_TT_UNTR_ONLY:
        kind_ok = (req_i.kind == dce_pkg::DCE_RQ_UNTRANSLATED);
      dce_pkg::DCE_TT_ALL:
        kind_ok = 1'b1;
      dce_pkg::DCE_TT_PASS:
        kind_ok = (req_i.kind == dce_pkg::DCE_RQ_UNTRANSLATED);
      dce_pkg::DCE_TT_RSVD:
        kind_ok = 1'b0;
    endcase
  end

  // verdict terms, each one step further down the priority chain
  wire blk_absent = ~present;
  wire blk_cfg    = present & cfg_bad;
  wire pass_cfg   = present & ~cfg_bad;
  wire blk_plat   = pass_cfg & over_mgw;
  wire pass_plat  = pass_cfg & ~over_mgw;
  wire blk_kind   = pass_plat & (~kind_ok | over_aw);
  wire go_ok      = pass_plat & kind_ok & ~over_aw;
  wire go_walk    = go_ok & tt_multi;
  wire go_pass    = go_ok & ~tt_multi;
  wire any_fault  = blk_absent | blk_cfg | blk_kind;

  // verdict for the current request
  always_comb begin
    rsp_nxt              = '0;
    rsp_nxt.act          = dce_pkg::DCE_ACT_BLOCK;
    if (go_walk) begin
      rsp_nxt.act        = dce_pkg::DCE_ACT_WALK;
      rsp_nxt.levels     = aw_levels;
      rsp_nxt.root_page  = root_pg;
    end else if (go_pass) begin
      rsp_nxt.act        = dce_pkg::DCE_ACT_PASS;
    end
    rsp_nxt.fault        = any_fault;
    rsp_nxt.fault_report = any_fault & ~flt_supp;
    rsp_nxt.cfg_fault    = cfg_bad;
    rsp_nxt.platform_err = blk_plat;
  end

  // next value of each stored word: a selected byte lane takes bus data
  wire [31:0] word_nxt [dce_pkg::DCE_NUM_RW];
  genvar gw, gl;
  generate
    for (gw = 0; gw < dce_pkg::DCE_NUM_RW; gw++) begin : g_word
      wire word_hit = wr_go & hit_rw & (reg_idx[1:0] == 2'(gw));
      for (gl = 0; gl < 4; gl++) begin : g_lane
        wire lane_wr = word_hit & wb_sel_i[gl];
        assign word_nxt[gw][8*gl +: 8] = lane_wr ? wb_dat_i[8*gl +: 8]
                                                 : regs_r[gw][8*gl +: 8];
      end
    end
  endgenerate

  // stored words; a single process owns the whole array
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      regs_r[0] <= 32'h0000_0000;
      regs_r[1] <= 32'h0000_0000;
      regs_r[2] <= 32'h0000_0000;
      regs_r[3] <= dce_pkg::DCE_CAPS_RST;
    end else begin
      regs_r <= word_nxt;
    end
  end

  // status word: live decode in the low bits, last verdict above them
  wire [3:0]  stat_live = {cfg_bad, present, tt_bad, aw_ok};
  wire [8:0]  stat_last = {rsp_r.platform_err, rsp_r.cfg_fault,
                           rsp_r.fault_report, rsp_r.fault, rsp_r.act,
                           rsp_r.levels};
  wire [31:0] stat_word = {19'h0_0000, stat_last, stat_live};

  // read select; unmapped reads return zero
  wire [31:0] rd_rw   = hit_rw ? regs_r[reg_idx[1:0]] : 32'h0000_0000;
  wire [31:0] rd_stat = hit_stat ? stat_word : 32'h0000_0000;
  wire [31:0] rd_mux  = rd_rw | rd_stat;

  // bus answer one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ack_r  <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end else begin
      ack_r  <= bus_go;
      rdat_r <= rd_mux;
    end
  end

  // registered verdict
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rsp_valid_r <= 1'b0;
      rsp_r       <= '0;
    end else begin
      rsp_valid_r <= req_valid_i;
      if (req_valid_i) begin
        rsp_r <= rsp_nxt;
      end
    end
  end

  assign wb_ack_o    = ack_r;
  assign wb_dat_o    = rdat_r;
  assign rsp_valid_o = rsp_valid_r;
  assign rsp_o       = rsp_r;

endmodule

`default_nettype wire

// *** test/dce_properties.sv ***
// Purpose: port properties of the context entry decoder
// Assumes: one clock, async active-low reset
// Notes:   bound to every decoder instance
`timescale 1ns/1ps
`default_nettype none
module dce_decode_checker (
  input wire logic                 clk_sys_i,
  input wire logic                 rst_b_i,
  input wire logic                 wb_cyc_i,
  input wire logic                 wb_stb_i,
  input wire logic                 wb_ack_o,
  input wire logic                 req_valid_i,
  input wire dce_pkg::dce_req_type req_i,
  input wire logic                 rsp_valid_o,
  input wire dce_pkg::dce_rsp_type rsp_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  // bus steps and verdict qualifiers
  sequence s_take; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_ack; wb_ack_o ##1 !wb_ack_o; endsequence
  wire r_w = rsp_valid_o;
  wire walk_w = r_w && rsp_o.act == dce_pkg::DCE_ACT_WALK;
  property p_ack; s_take |=> s_ack; endproperty
  a_ack: assert property (p_ack)
    else $error("ack not a one cycle pulse after take");
  property p_rsp; req_valid_i |=> r_w; endproperty
  a_rsp: assert property (p_rsp)
    else $error("no verdict one cycle after request");
  property p_quiet; !req_valid_i |=> !r_w; endproperty
  a_quiet: assert property (p_quiet)
    else $error("verdict without request");
  property p_lv; walk_w |-> rsp_o.levels inside {2, 3, 4, 6}; endproperty
  a_lv: assert property (p_lv)
    else $error("bad walk depth");
  property p_bound;
    walk_w && rsp_o.levels == 3'h4 |-> ($past(req_i.addr) >> 48) == 64'h0;
  endproperty
  a_bound: assert property (p_bound)
    else $error("walk above width");
  property p_pass;
    r_w && rsp_o.act == dce_pkg::DCE_ACT_PASS |-> $past(req_i.kind) == 2'h0;
  endproperty
  a_pass: assert property (p_pass)
    else $error("pass for non untranslated kind");
  property p_rep; r_w && rsp_o.fault_report |-> rsp_o.fault; endproperty
  a_rep: assert property (p_rep)
    else $error("report without fault");
  property p_cfg; r_w && rsp_o.cfg_fault |-> rsp_o.act == 2'h0; endproperty
  a_cfg: assert property (p_cfg)
    else $error("bad entry not blocked");
  property p_plat;
    r_w && rsp_o.platform_err |-> rsp_o.act == 2'h0 && !rsp_o.fault;
  endproperty
  a_plat: assert property (p_plat)
    else $error("platform error misreported");
endmodule
bind dce_decode dce_decode_checker i_chk (.clk_sys_i(clk_sys_i),
  .rst_b_i(rst_b_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .req_valid_i(req_valid_i), .req_i(req_i),
  .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o));
`default_nettype wire

// *** test/dce_dev_model.sv ***
// Purpose: i/o device issuing one request at a time
// Assumes: verdict comes within a few cycles
// Notes:   address lines show a changed pattern when idle
`timescale 1ns/1ps
`default_nettype none
module dce_dev_model (
  input  wire logic            clk_sys_i,
  input  wire logic            rsp_valid_i,
  output logic                 req_valid_o,
  output dce_pkg::dce_req_type req_o
);
  // idle at time zero
  initial begin
    req_valid_o = 1'b0;
    req_o = '0;
  end
  // present one request, then wait a bounded time for its verdict
  task automatic issue(input dce_pkg::dce_kind_type k,
                       input logic [63:0] a, output bit ok);
    int n;
    @(posedge clk_sys_i);
    req_valid_o <= 1'b1;
    req_o.kind <= k;
    req_o.addr <= a;
    @(posedge clk_sys_i);
    req_valid_o <= 1'b0;
    req_o.addr <= ~a;
    ok = 1'b0;
    for (n = 0; n < 8 && !ok; n++) begin
      @(posedge clk_sys_i);
      ok = rsp_valid_i;
    end
  endtask
endmodule
`default_nettype wire

// *** test/tb.sv ***
// Purpose: self-checking bench for the context entry decoder
// Assumes: one verdict per request, wishbone register access
// Notes:   entries and capability sets come from tables
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_sys_i, rst_b_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic req_valid_i, rsp_valid_o;
  dce_pkg::dce_req_type req_i;
  dce_pkg::dce_rsp_type rsp_o;
  int err_count, comparisons;
  bit ok;
  logic [5:0] ex;
  logic [63:0] a;
  logic [95:0] tbl[$] = '{96'h2_00000000_12345001, 96'h4_00000000_12345007,
    96'h4_00000000_12345009, 96'h2_00000000_1234500D, 96'h0,
    96'h1_00000000_12345001,
    96'h82_00000000_12345001, 96'h2_00000000_12345011,
    96'h7A_00000000_12345001, 96'h2_00010000_12345001,
    96'h3_00000000_12345001, 96'h0_00000000_12345001,
    96'h85_00000000_12345FF2};
  logic [31:0] cq[$] = '{dce_pkg::DCE_CAPS_RST, 32'h0040_1F30};
  dce_decode i_dce_decode (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .req_valid_i(req_valid_i),
    .req_i(req_i), .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o));
  dce_dev_model i_dce_dev_model (.clk_sys_i(clk_sys_i),
    .rsp_valid_i(rsp_valid_o), .req_valid_o(req_valid_i), .req_o(req_i));
  // free-running clock
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  task automatic check(input logic [63:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // one classic wishbone cycle, bounded wait for ack
  task automatic wb(input logic w, input logic [7:0] ad,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk_sys_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= ad;
    wb_dat_i <= d;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_sys_i);
      if (wb_ack_o === 1'b1) break;
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_dat_i <= ~d;
    if (n == 20) begin
      err_count++;
      tally_and_finish();
    end
  endtask
  // expected {act, fault, report, cfg, platform} from entry and caps
  function automatic logic [5:0] model(input logic [95:0] e,
      input logic [31:0] c, input int k, input logic [63:0] ad);
    int aw, w, tt;
    logic bad, f, cf, pe;
    logic [1:0] act;
    tt = e[3:2];
    aw = e[66:64];
    w = aw == 0 ? 30 : aw == 1 ? 39 : aw == 2 ? 48 : 64;
    bad = e[71] | (e[11:4] != 0) | tt == 3 | aw > 4 | aw == 3;
    bad = bad | !c[8 + aw] | (tt == 1 & !c[13]) | (tt == 2 & !c[14]);
    bad = bad | (tt < 2 & (e[63:0] >> c[6:0]) != 0);
    act = 2'h0;
    f = 1'b1;
    cf = 1'b0;
    pe = 1'b0;
    if (e[0] && bad) cf = 1'b1;
    else if (e[0] && k != 1 && (ad >> c[22:16]) != 0) begin
      pe = 1'b1;
      f = 1'b0;
    end else if (e[0] && (k == 0 || tt == 1) && (ad >> w) == 0) begin
      f = 1'b0;
      act = tt == 2 ? 2'h1 : 2'h3;
    end
    return {act, f, f & !e[1], cf, pe};
  endfunction
  // reset, registers, then every entry against every request kind
  initial begin
    {rst_b_i, wb_cyc_i, wb_stb_i, wb_we_i} = 4'h0;
    {wb_adr_i, wb_dat_i, wb_sel_i} = '0;
    wb_sel_i = 4'hF;
    void'($urandom(32'h3CCD));
    repeat (6) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    wb(1'b0, 8'h0C, 32'h0, rd);
    check(rd, dce_pkg::DCE_CAPS_RST);
    wb(1'b0, 8'h14, 32'h0, rd);
    check(rd, 32'h0);
    foreach (cq[j]) begin
      wb(1'b1, 8'h0C, cq[j], rd);
      foreach (tbl[i]) begin
        wb(1'b1, 8'h00, tbl[i][31:0], rd);
        wb(1'b1, 8'h04, tbl[i][63:32], rd);
        wb(1'b1, 8'h08, tbl[i][95:64], rd);
        for (int k = 0; k < 6; k++) begin
          a = {$urandom, $urandom} >> ($urandom % 64);
          i_dce_dev_model.issue(dce_pkg::dce_kind_type'(k % 3), a, ok);
          if (!ok) begin
            err_count++;
            tally_and_finish();
          end
          ex = model(tbl[i], cq[j], k % 3, a);
          check(rsp_o.act, ex[5:4]);
          check(rsp_o.fault, ex[3]);
          check(rsp_o.fault_report, ex[2]);
          check(rsp_o.cfg_fault, ex[1]);
          check(rsp_o.platform_err, ex[0]);
          wb(1'b0, dce_pkg::DCE_OFS_STATUS, 32'h0, rd);
          check(rd[12:7], {ex[0], ex[1], ex[2], ex[3], ex[5:4]});
          check(rd[3:2], {ex[1], tbl[i][0]});
          if (ex[5:4] == 2'h3) begin
            check(rsp_o.levels, tbl[i][66] ? 6 : tbl[i][65:64] + 2);
            check(rsp_o.root_page, tbl[i][63:12]);
          end
        end
      end
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
